// ===== rtl/mdwr_pkg.sv
// Purpose: constants and carrier types for the window, row duty and ramp configuration block
// Assumes: 8-bit register file reached through the serial bus register port
// Notes:   one localparam per offset, single-bit field and reset value
package mdwr_pkg;

  // register offsets
  localparam logic [7:0] OFF_INPUT_MODE   = 8'h01;
  localparam logic [7:0] OFF_FIRST_COLUMN = 8'h03;
  localparam logic [7:0] OFF_LAST_COLUMN  = 8'h04;
  localparam logic [7:0] OFF_FIRST_ROW    = 8'h05;
  localparam logic [7:0] OFF_LAST_ROW     = 8'h06;
  localparam logic [7:0] OFF_DUTY_LOW     = 8'h07;
  localparam logic [7:0] OFF_DUTY_HIGH    = 8'h08;
  localparam logic [7:0] OFF_RAMP_CTL     = 8'h09;
  localparam logic [7:0] OFF_RAMP_BIAS    = 8'h0a;
  localparam logic [7:0] OFF_DAC_MAX      = 8'h0b;
  localparam logic [7:0] OFF_PIXEL_BIAS   = 8'h0c;
  localparam logic [7:0] OFF_GAMMA_CTL    = 8'h0d;

  // reset values
  localparam logic [7:0] RST_POSITION   = 8'h06;
  localparam logic [7:0] RST_DUTY       = 8'h00;
  localparam logic [7:0] RST_RAMP_CTL   = 8'h01;
  localparam logic [7:0] RST_RAMP_BIAS  = 8'h44;
  localparam logic [7:0] RST_DAC_MAX    = 8'h80;
  localparam logic [7:0] RST_PIXEL_BIAS = 8'h01;
  localparam logic [7:0] RST_GAMMA_CTL  = 8'h00;
  localparam logic [7:0] RST_INPUT_MODE = 8'h00;

  // field positions
  localparam int BIT_WRITE_PROTECT = 7;
  localparam int BIT_STEREO_HIGH   = 4;
  localparam int BIT_RAMP_MONITOR  = 5;
  localparam int BIT_RAMP_FORCE    = 3;
  localparam int BIT_RAMP_RETURN   = 2;
  localparam int BIT_EXT_REF       = 3;
  localparam int BIT_PUMP_HOLD     = 4;
  localparam int BIT_SAMPLE_HOLD   = 3;

  // write masks keep reserved bits at reset value
  localparam logic [7:0] MASK_DUTY_HIGH  = 8'h13;
  localparam logic [7:0] MASK_RAMP_CTL   = 8'h2f;
  localparam logic [7:0] MASK_PIXEL_BIAS = 8'h0f;
  localparam logic [7:0] MASK_GAMMA_CTL  = 8'h1f;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RETURN_SHORT_NS = 500;
  localparam int RETURN_LONG_NS  = 800;
  localparam logic [7:0] RETURN_SHORT_CYC = 8'((RETURN_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RETURN_LONG_CYC  = 8'((RETURN_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // geometry and duty
  localparam int          ARRAY_COLUMNS = 1292;
  localparam int          ARRAY_ROWS    = 1036;
  localparam logic [9:0]  DUTY_FULL_MAX = 10'd527;
  localparam logic [7:0]  WINDOW_SHIFT  = 8'h06;

  // ramp start delay codes
  localparam logic [1:0] DELAY_EARLY = 2'b00;
  localparam logic [1:0] DELAY_NONE  = 2'b01;
  localparam logic [1:0] DELAY_LATE  = 2'b10;

  typedef enum logic [2:0] {
    MDWR_RAMP_IDLE   = 3'b001,
    MDWR_RAMP_RUN    = 3'b010,
    MDWR_RAMP_RETURN = 3'b100
  } mdwr_ramp_type;

  // window placement carried to the scan engine
  typedef struct packed {
    logic [10:0] col_first;
    logic [10:0] col_last;
    logic [10:0] row_first;
    logic [10:0] row_last;
  } mdwr_window_type;

  // analog trims carried to the ramp and sensor
  typedef struct packed {
    logic       ramp_monitor_enable;
    logic [3:0] ramp_buffer_bias;
    logic [3:0] ramp_amp_bias;
    logic [7:0] ramp_dac_maximum;
    logic [2:0] pixel_bias_select;
    logic       external_reference_enable;
    logic [2:0] gamma_sense_current_code;
    logic       sense_sample_hold_enable;
  } mdwr_trim_type;

  typedef struct packed {
    logic [7:0]    input_mode;
    logic [7:0]    first_col;
    logic [7:0]    last_col;
    logic [7:0]    first_row;
    logic [7:0]    last_row;
    logic [7:0]    duty_low;
    logic [7:0]    duty_high;
    logic [7:0]    ramp_ctl;
    logic [7:0]    ramp_bias;
    logic [7:0]    dac_max;
    logic [7:0]    pixel_bias;
    logic [7:0]    gamma_ctl;
    logic [7:0]    rd_data;
    logic [2:0]    vsync_sync;
    logic [1:0]    stereo_sync;
    logic [2:0]    hsync_sync;
    logic [1:0]    frame_sync;
    logic          stereo_frame;
    logic          frame_enabled;
    logic [10:0]   line_count;
    logic          row_active;
    logic          stereo_cur;
    mdwr_ramp_type ramp_state;
    logic [7:0]    ramp_count;
    logic [7:0]    ramp_level;
    logic          ramp_half_late;
    logic          pump_pause;
  } mdwr_state_type;

endpackage

// ===== rtl/mdwr_config.sv
// Purpose: register file, window placement, row duty and ramp timing of the scan engine
// Assumes: mclk 100 MHz; sync, stereo and blanking inputs arrive from other domains
// Notes:   registers written through the serial bus byte port, read back the same way
`timescale 1ns/1ps
`default_nettype none

module mdwr_config
  import mdwr_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  output logic [7:0]           reg_rdata,
  input  wire logic            vsync,
  input  wire logic            hsync,
  input  wire logic            stereo_enable,
  input  wire logic            frame_blank,
  input  wire logic            stereo_mode_select,
  input  wire logic            gamma_sample,
  output mdwr_window_type      window,
  output mdwr_trim_type        trims,
  output logic                 row_active,
  output logic                 row_black,
  output logic [7:0]           ramp_level,
  output logic                 ramp_half_late,
  output logic                 ramp_returning,
  output logic                 converter_pause,
  output logic                 frame_enabled
);

  mdwr_state_type cur_ff;
  mdwr_state_type nxt_cur;

  // window edge: offset inward from the near or far array edge, centred at reset
  function automatic logic [10:0] edge_pos(input logic [7:0] pos, input int span, input logic far);
    logic [10:0] res;
    res = far ? 11'(span - 1 - int'(pos)) : 11'(pos);
    return res;
  endfunction

  // duty length in line cycles, zero meaning whole frame
  function automatic logic [10:0] duty_lines(input logic [9:0] v);
    logic [10:0] res;
    res = (v == 10'd0 || v > DUTY_FULL_MAX) ? 11'd0 : {v, 1'b0};
    return res;
  endfunction

  logic [9:0]  duty_value;
  logic [10:0] duty_len;
  logic        vs_fall;
  logic        hs_rise;
  logic        duty_in_range;

  always_comb begin
    duty_value    = {cur_ff.duty_high[1:0], cur_ff.duty_low};
    duty_len      = duty_lines(duty_value);
    vs_fall       = cur_ff.vsync_sync[2] & ~cur_ff.vsync_sync[1];
    // edge taken between synced stage and its delayed copy, never the first stage
    hs_rise       = cur_ff.hsync_sync[1] & ~cur_ff.hsync_sync[2];
    duty_in_range = (duty_len == 11'd0) || (cur_ff.line_count < duty_len);
  end

  // single next-state process for the whole block
  always_comb begin
    logic       wp;
    logic       run_active;
    logic [7:0] ret_cyc;
    wp         = 1'b0;
    run_active = 1'b0;
    ret_cyc    = 8'h00;
    nxt_cur    = cur_ff;

    // input synchronisers: first stage read only by second stage
    nxt_cur.vsync_sync  = {cur_ff.vsync_sync[1:0], vsync};
    nxt_cur.hsync_sync  = {cur_ff.hsync_sync[1:0], hsync};
    nxt_cur.stereo_sync = {cur_ff.stereo_sync[0], stereo_enable};
    nxt_cur.frame_sync  = {cur_ff.frame_sync[0], gamma_sample & frame_blank};

    // register writes; protect bit locks every other register
    wp = cur_ff.input_mode[BIT_WRITE_PROTECT];
    if (reg_wr) begin
      if (reg_addr == OFF_INPUT_MODE) begin
        nxt_cur.input_mode = reg_wdata;
      end else if (!wp) begin
        case (reg_addr)
          OFF_FIRST_COLUMN: nxt_cur.first_col  = reg_wdata;
          OFF_LAST_COLUMN:  nxt_cur.last_col   = reg_wdata;
          OFF_FIRST_ROW:    nxt_cur.first_row  = reg_wdata;
          OFF_LAST_ROW:     nxt_cur.last_row   = reg_wdata;
          OFF_DUTY_LOW:     nxt_cur.duty_low   = reg_wdata;
          OFF_DUTY_HIGH:    nxt_cur.duty_high  = reg_wdata & MASK_DUTY_HIGH;
          OFF_RAMP_CTL:     nxt_cur.ramp_ctl   = reg_wdata & MASK_RAMP_CTL;
          OFF_RAMP_BIAS:    nxt_cur.ramp_bias  = reg_wdata;
          OFF_DAC_MAX:      nxt_cur.dac_max    = reg_wdata;
          OFF_PIXEL_BIAS:   nxt_cur.pixel_bias = reg_wdata & MASK_PIXEL_BIAS;
          OFF_GAMMA_CTL:    nxt_cur.gamma_ctl  = reg_wdata & MASK_GAMMA_CTL;
          default: ;
        endcase
      end
    end

    // read data registered; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        OFF_INPUT_MODE:   nxt_cur.rd_data = cur_ff.input_mode;
        OFF_FIRST_COLUMN: nxt_cur.rd_data = cur_ff.first_col;
        OFF_LAST_COLUMN:  nxt_cur.rd_data = cur_ff.last_col;
        OFF_FIRST_ROW:    nxt_cur.rd_data = cur_ff.first_row;
        OFF_LAST_ROW:     nxt_cur.rd_data = cur_ff.last_row;
        OFF_DUTY_LOW:     nxt_cur.rd_data = cur_ff.duty_low;
        OFF_DUTY_HIGH:    nxt_cur.rd_data = cur_ff.duty_high;
        OFF_RAMP_CTL:     nxt_cur.rd_data = cur_ff.ramp_ctl;
        OFF_RAMP_BIAS:    nxt_cur.rd_data = cur_ff.ramp_bias;
        OFF_DAC_MAX:      nxt_cur.rd_data = cur_ff.dac_max;
        OFF_PIXEL_BIAS:   nxt_cur.rd_data = cur_ff.pixel_bias;
        OFF_GAMMA_CTL:    nxt_cur.rd_data = cur_ff.gamma_ctl;
        default:          nxt_cur.rd_data = 8'h00;
      endcase
    end

    // stereo flag caught at sync fall, applied from the next frame on
    if (vs_fall) begin
      nxt_cur.frame_enabled = cur_ff.stereo_frame;
      nxt_cur.stereo_frame  = cur_ff.stereo_sync[1];
      nxt_cur.stereo_cur    = stereo_mode_select;
      nxt_cur.line_count    = 11'd0;
    end else if (hs_rise) begin
      nxt_cur.line_count = cur_ff.line_count + 11'd1;
    end

    // row duty: enabled stereo frames and mono run the programmed duty;
    // on the non-enabled frame bit 4 set keeps rows active the whole frame, clear runs the programmed duty
    if (cur_ff.stereo_cur && !cur_ff.frame_enabled) begin
      if (cur_ff.duty_high[BIT_STEREO_HIGH]) begin
        run_active = 1'b1;
      end else begin
        run_active = duty_in_range;
      end
    end else begin
      run_active = duty_in_range;
    end
    nxt_cur.row_active = run_active;

    // ramp sequencer: start at line edge, rise, then fly back
    ret_cyc = cur_ff.ramp_ctl[BIT_RAMP_RETURN] ? RETURN_LONG_CYC : RETURN_SHORT_CYC;
    nxt_cur.ramp_half_late = (cur_ff.ramp_ctl[1:0] == DELAY_LATE);
    case (cur_ff.ramp_state)
      MDWR_RAMP_IDLE: begin
        nxt_cur.ramp_level = 8'h00;
        if (hs_rise) begin
          nxt_cur.ramp_state = MDWR_RAMP_RUN;
          // early start skips the first step, no delay and late start both begin at zero
          nxt_cur.ramp_level = (cur_ff.ramp_ctl[1:0] == DELAY_EARLY) ? 8'h01 : 8'h00;
        end
      end
      MDWR_RAMP_RUN: begin
        if (cur_ff.ramp_level >= cur_ff.dac_max) begin
          nxt_cur.ramp_state = MDWR_RAMP_RETURN;
          nxt_cur.ramp_count = ret_cyc;
        end else begin
          nxt_cur.ramp_level = cur_ff.ramp_level + 8'h01;
        end
      end
      MDWR_RAMP_RETURN: begin
        nxt_cur.ramp_level = 8'h00;
        if (cur_ff.ramp_count <= 8'h01) begin
          nxt_cur.ramp_state = MDWR_RAMP_IDLE;
          nxt_cur.ramp_count = 8'h00;
        end else begin
          nxt_cur.ramp_count = cur_ff.ramp_count - 8'h01;
        end
      end
      default: begin
        nxt_cur.ramp_state = MDWR_RAMP_IDLE;
        nxt_cur.ramp_level = 8'h00;
      end
    endcase

    // converter paused only while a gamma sample is taken in blanking
    nxt_cur.pump_pause = cur_ff.gamma_ctl[BIT_PUMP_HOLD] & cur_ff.frame_sync[1];
  end

  // state register; reset loads constants only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '{
        input_mode: RST_INPUT_MODE,
        first_col:  RST_POSITION,
        last_col:   RST_POSITION,
        first_row:  RST_POSITION,
        last_row:   RST_POSITION,
        duty_low:   RST_DUTY,
        duty_high:  RST_DUTY,
        ramp_ctl:   RST_RAMP_CTL,
        ramp_bias:  RST_RAMP_BIAS,
        dac_max:    RST_DAC_MAX,
        pixel_bias: RST_PIXEL_BIAS,
        gamma_ctl:  RST_GAMMA_CTL,
        ramp_state: MDWR_RAMP_IDLE,
        default:    '0
      };
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs
  always_comb begin
    window.col_first = edge_pos(cur_ff.first_col, ARRAY_COLUMNS, 1'b0);
    window.col_last  = edge_pos(cur_ff.last_col, ARRAY_COLUMNS, 1'b1);
    window.row_first = edge_pos(cur_ff.first_row, ARRAY_ROWS, 1'b0);
    window.row_last  = edge_pos(cur_ff.last_row, ARRAY_ROWS, 1'b1);
    trims.ramp_monitor_enable       = cur_ff.ramp_ctl[BIT_RAMP_MONITOR];
    trims.ramp_buffer_bias          = cur_ff.ramp_bias[7:4];
    trims.ramp_amp_bias             = cur_ff.ramp_bias[3:0];
    trims.ramp_dac_maximum          = cur_ff.dac_max;
    trims.pixel_bias_select         = cur_ff.pixel_bias[2:0];
    trims.external_reference_enable = cur_ff.pixel_bias[BIT_EXT_REF];
    trims.gamma_sense_current_code  = cur_ff.gamma_ctl[2:0];
    trims.sense_sample_hold_enable  = cur_ff.gamma_ctl[BIT_SAMPLE_HOLD];
  end

  assign reg_rdata       = cur_ff.rd_data;
  assign row_active      = cur_ff.row_active;
  assign row_black       = ~cur_ff.row_active;
  // test bit overrides the ramp with full scale
  assign ramp_level      = cur_ff.ramp_ctl[BIT_RAMP_FORCE] ? 8'hff : cur_ff.ramp_level;
  assign ramp_half_late  = cur_ff.ramp_half_late;
  assign ramp_returning  = (cur_ff.ramp_state == MDWR_RAMP_RETURN);
  assign converter_pause = cur_ff.pump_pause;
  assign frame_enabled   = cur_ff.frame_enabled;

endmodule

`default_nettype wire

// ===== verification/mdwr_host.sv
// Purpose: host model that configures the block over its byte port
// Assumes: strobes move 1 ns after the mclk rise and last one cycle
// Notes:   reserved bits and reference select are never changed
`timescale 1ns/1ps
`default_nettype none
module mdwr_host
  import mdwr_pkg::*;
(
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle port; released data shows the inverse, never a stale byte
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == OFF_RAMP_CTL) v[4] = 1'b0; // reserved kept at reset
    if (a == OFF_PIXEL_BIAS) v[BIT_EXT_REF] = 1'b0; // internal reference only
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask

  // move a window edge pair, sum stays at twice the reset position
  task automatic pair(input logic [7:0] a, input logic [7:0] v);
    wr(a, v);
    wr(a + 8'h01, 8'h0c - v);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== verification/mdwr_config_props.sv
// Purpose: port checker for the window, duty and ramp block
// Assumes: protect flag mirrored here from writes to the mode register
// Notes:   flyback length measured with a small counter
`timescale 1ns/1ps
`default_nettype none
module mdwr_config_props
  import mdwr_pkg::*;
(
  input wire logic            mclk,
  input wire logic            reset_n,
  input wire logic            reg_wr,
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire mdwr_window_type window,
  input wire mdwr_trim_type   trims,
  input wire logic            row_active,
  input wire logic            row_black,
  input wire logic [7:0]      ramp_level,
  input wire logic            ramp_half_late,
  input wire logic            ramp_returning
);
  logic       wp_ff;
  logic       fly_ff;
  logic       fly_sel_ff;
  logic [7:0] ret_cnt_ff;
  logic       wr_ok;
  assign wr_ok = reg_wr && !wp_ff;

  // mirror of the protect bit and count of flyback cycles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_ff <= 1'b0;
      fly_ff <= RST_RAMP_CTL[BIT_RAMP_RETURN];
      fly_sel_ff <= 1'b0;
      ret_cnt_ff <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == OFF_INPUT_MODE) wp_ff <= reg_wdata[BIT_WRITE_PROTECT];
      if (wr_ok && reg_addr == OFF_RAMP_CTL) fly_ff <= reg_wdata[BIT_RAMP_RETURN];
      // flyback select frozen while returning, as the sequencer loads it on entry
      if (!ramp_returning) fly_sel_ff <= fly_ff;
      ret_cnt_ff <= ramp_returning ? ret_cnt_ff + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_ctl_wr;
    wr_ok && reg_addr == OFF_RAMP_CTL;
  endsequence

  a_black_inverse: assert property (row_black == !row_active)
    else $error("row black not inverse of row active");
  a_first_column: assert property (wr_ok && reg_addr == OFF_FIRST_COLUMN |=>
    window.col_first == {3'b000, $past(reg_wdata)}) else $error("first column wrong");
  a_last_row: assert property (wr_ok && reg_addr == OFF_LAST_ROW |=>
    window.row_last == 11'd1035 - {3'b000, $past(reg_wdata)}) else $error("last row wrong");
  a_dac_max: assert property (wr_ok && reg_addr == OFF_DAC_MAX |=>
    trims.ramp_dac_maximum == $past(reg_wdata)) else $error("dac maximum wrong");
  a_monitor_bit: assert property (s_ctl_wr |=>
    trims.ramp_monitor_enable == $past(reg_wdata[5])) else $error("monitor bit wrong");
  a_force_high: assert property (s_ctl_wr ##0 reg_wdata[3] |=> ##1
    ramp_level == 8'hff) else $error("ramp not forced high");
  a_half_late: assert property (s_ctl_wr |=> ##1
    ramp_half_late == ($past(reg_wdata[1:0], 2) == DELAY_LATE)) else $error("delay flag wrong");
  a_return_time: assert property ($fell(ramp_returning) |->
    ret_cnt_ff == (fly_sel_ff ? RETURN_LONG_CYC : RETURN_SHORT_CYC)) else $error("flyback length");
  a_protect_hold: assert property (reg_wr && wp_ff && reg_addr == OFF_FIRST_COLUMN |=>
    $stable(window.col_first)) else $error("protected write took effect");
endmodule
`default_nettype wire

// ===== verification/mdwr_config_tb.sv
// Purpose: self-checking bench for the window, duty and ramp block
// Assumes: 100 MHz mclk, inputs moved 1 ns after the rising edge
// Notes:   frames are three lines long, enough to see short duties
`timescale 1ns/1ps
`default_nettype none
module mdwr_config_tb
  import mdwr_pkg::*;
;
  logic            mclk, reset_n, reg_wr, reg_rd, vsync, hsync, stereo_enable;
  logic            frame_blank, stereo_mode_select, gamma_sample, row_active, row_black;
  logic            ramp_half_late, ramp_returning, converter_pause, frame_enabled;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, ramp_level, d;
  mdwr_window_type window;
  mdwr_trim_type   trims;
  int              error_cnt = 0;
  int              total_checks = 0;

  mdwr_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  mdwr_config dut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vsync(vsync),
    .hsync(hsync), .stereo_enable(stereo_enable), .frame_blank(frame_blank),
    .stereo_mode_select(stereo_mode_select), .gamma_sample(gamma_sample), .window(window),
    .trims(trims), .row_active(row_active), .row_black(row_black), .ramp_level(ramp_level),
    .ramp_half_late(ramp_half_late), .ramp_returning(ramp_returning),
    .converter_pause(converter_pause), .frame_enabled(frame_enabled));

  always #5 mclk = ~mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one frame of three lines; exp holds row activity per line
  task automatic frame(input logic [2:0] exp);
    vsync = 1'b1;
    tick(4);
    vsync = 1'b0;
    for (int l = 0; l < 3; l++) begin
      tick(20);
      chk({row_active, row_black}, {exp[l], !exp[l]});
      hsync = 1'b1;
      tick(4);
      hsync = 1'b0;
      tick(250);
    end
  endtask

  task automatic t_reset();
    logic [7:0] off [12] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                             8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] rv [12] = '{8'h00, 8'h06, 8'h06, 8'h06, 8'h06, 8'h00, 8'h00, 8'h01,
                            8'h44, 8'h80, 8'h01, 8'h00};
    for (int i = 0; i < 12; i++) begin
      host.rd(off[i], d);
      chk(d, rv[i]);
    end
    host.rd(8'h0e, d);
    chk(d, 8'h00);
    chk(window.col_last, 16'(ARRAY_COLUMNS - 7));
    chk(window.row_last, 16'(ARRAY_ROWS - 7));
  endtask

  // both extreme shifts of the window, then back to centre
  task automatic t_window();
    for (int i = 0; i < 2; i++) begin
      host.pair(OFF_FIRST_COLUMN, 8'(i * 12));
      host.pair(OFF_FIRST_ROW, 8'(12 - i * 12));
      chk(window.col_first, 16'(i * 12));
      chk(window.col_last, 16'(ARRAY_COLUMNS - 1 - (12 - i * 12)));
      chk(window.row_first, 16'(12 - i * 12));
      chk(window.row_last, 16'(ARRAY_ROWS - 1 - i * 12));
    end
    host.pair(OFF_FIRST_COLUMN, 8'h06);
    host.pair(OFF_FIRST_ROW, 8'h06);
  endtask

  // duty 1, 513 (high bits count), 0 and 528 (full frame)
  task automatic t_duty();
    logic [7:0] lo [4] = '{8'h01, 8'h01, 8'h00, 8'h10};
    logic [7:0] hi [4] = '{8'h00, 8'h02, 8'h00, 8'h02};
    logic [2:0] ex [4] = '{3'b011, 3'b111, 3'b111, 3'b111};
    for (int i = 0; i < 4; i++) begin
      host.wr(OFF_DUTY_LOW, lo[i]);
      host.wr(OFF_DUTY_HIGH, hi[i]);
      frame(ex[i]);
    end
  endtask

  task automatic t_ramp();
    for (int c = 0; c < 3; c++) begin
      host.wr(OFF_RAMP_CTL, 8'(c));
      tick(2);
      chk(ramp_half_late, c == 2);
    end
    host.wr(OFF_RAMP_CTL, 8'h36);
    host.rd(OFF_RAMP_CTL, d);
    chk(d, 8'h26);
    chk(trims.ramp_monitor_enable, 1'b1);
    frame(3'b111);
    host.wr(OFF_RAMP_CTL, 8'h08);
    tick(3);
    chk(ramp_level, 8'hff);
    host.wr(OFF_RAMP_CTL, RST_RAMP_CTL);
  endtask

  task automatic t_trims();
    host.wr(OFF_RAMP_BIAS, 8'h70);
    host.wr(OFF_DAC_MAX, 8'hc0);
    host.wr(OFF_PIXEL_BIAS, 8'h0f);
    host.wr(OFF_GAMMA_CTL, 8'h18); // current code left as at reset, no settling wait
    chk({trims.ramp_buffer_bias, trims.ramp_amp_bias}, 8'h70);
    chk(trims.ramp_dac_maximum, 8'hc0);
    chk({trims.external_reference_enable, trims.pixel_bias_select}, 4'h7);
    frame_blank = 1'b1;
    gamma_sample = 1'b1; // sampling only while blanked
    tick(6);
    chk(converter_pause, 1'b1);
    gamma_sample = 1'b0;
    frame_blank = 1'b0;
    tick(6);
    chk(converter_pause, 1'b0);
    // code changed last, after the sampling is over
    host.wr(OFF_GAMMA_CTL, 8'h1f);
    chk({trims.sense_sample_hold_enable, trims.gamma_sense_current_code}, 4'hf);
  endtask

  task automatic t_protect();
    host.wr(OFF_INPUT_MODE, 8'h80);
    host.pair(OFF_FIRST_COLUMN, 8'h09);
    chk(window.col_first, 16'h0006);
    chk(window.col_last, 16'(ARRAY_COLUMNS - 7));
    host.rd(OFF_INPUT_MODE, d);
    chk(d, 8'h80);
    host.wr(OFF_INPUT_MODE, 8'h00);
    host.pair(OFF_FIRST_COLUMN, 8'h09);
    chk(window.col_first, 16'h0009);
    chk(window.col_last, 16'(ARRAY_COLUMNS - 4));
    host.pair(OFF_FIRST_COLUMN, 8'h06);
  endtask

  // stereo input caught at one frame start shows up a frame later
  task automatic t_stereo();
    stereo_mode_select = 1'b1;
    host.wr(OFF_DUTY_LOW, 8'h01);
    host.wr(OFF_DUTY_HIGH, 8'h10);
    frame(3'b011);
    stereo_enable = 1'b0;
    frame(3'b011);
    chk(frame_enabled, 1'b1);
    frame(3'b111);
    chk(frame_enabled, 1'b0);
    host.wr(OFF_DUTY_HIGH, 8'h00);
    frame(3'b011);
  endtask

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    {vsync, hsync, frame_blank, stereo_mode_select, gamma_sample} = 5'h00;
    stereo_enable = 1'b1;
    tick(6);
    reset_n = 1'b1;
    t_reset();
    t_window();
    t_duty();
    t_ramp();
    t_trims();
    t_protect();
    t_stereo();
    test_done();
  end

  // cut a hang well past the expected run of about 76 us
  initial begin
    #500000;
    error_cnt++;
    test_done();
  end
endmodule

bind mdwr_config mdwr_config_props u_props (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .window(window), .trims(trims),
  .row_active(row_active), .row_black(row_black), .ramp_level(ramp_level),
  .ramp_half_late(ramp_half_late), .ramp_returning(ramp_returning));
`default_nettype wire
